// File: core/orfs_local_cache.v
// Purpose: On-chip cache of saved local register sets
// Assumes: One set moves per save or restore pulse, LIFO
// Notes: Overflow beyond depth drops the oldest set silently
`include "orfs_regs.vh"
module orfs_local_cache (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_save,
  input wire i_restore,
  input wire [511:0] i_set,
  output reg [511:0] o_set,
  output wire o_empty
);
  reg [511:0] mem [0:`ORFS_CACHE_DEPTH-1];
  reg [`ORFS_CACHE_AW:0] count;
  reg [`ORFS_CACHE_AW-1:0] top;
  wire [`ORFS_CACHE_AW-1:0] top_m1 = top - 1'b1;
  assign o_empty = (count == 3'h0);
  always @(posedge i_clk_sys) begin
    if (i_save) begin
      mem[top] <= i_set; // [RL9]
    end
    o_set <= mem[top_m1];
  end
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= 3'h0;
      top <= 2'h0;
    end else if (i_save) begin
      top <= top + 1'b1;
      if (count != 3'h4) begin
        count <= count + 1'b1;
      end
    end else if (i_restore && !o_empty) begin
      top <= top_m1;
      count <= count - 1'b1;
    end
  end
endmodule // orfs_local_cache

// File: core/orfs_regfile.v
// Purpose: Global and local operand registers, literals, scoreboard
// Assumes: Issue logic presents operands and write-back in one clock domain
// Notes: Operand codes 0-15 global, 16-31 local, literal flag selects 0-31
// Function
// [RL1] Sixteen 32-bit globals kept across calls
// [RL2] Global fifteen holds the frame pointer
// [RL3] Global zero loaded with identification at reset
// [RL4] Identification readable at fixed mapped address
// [RL5] Call allocates fresh locals, saves caller set
// [RL6] Locals zero, one, two hold pointers
// [RL7] New locals are left uninitialised
// [RL8] Literal operands supply values zero to 31
// [RL9] Saved local sets held in on-chip cache
// [RL10] Multi-cycle destination marks scoreboard busy
// [RL11] Independent instructions issue past pending result
// [RL12] Reader of busy register stalls
// [RL13] Operands only from registers or literals
// [RL14] Write-back clears the busy bit
`include "orfs_regs.vh"
module orfs_regfile (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire [4:0] i_src_a,
  input wire i_src_a_lit,
  input wire [4:0] i_src_b,
  input wire i_src_b_lit,
  input wire i_issue,
  input wire i_dst_en,
  input wire [4:0] i_dst,
  input wire [1:0] i_dst_cnt,
  input wire i_multi,
  input wire i_wb_en,
  input wire [4:0] i_wb_reg,
  input wire [31:0] i_wb_data,
  input wire i_wb_pending,
  input wire i_call,
  input wire i_ret,
  input wire [31:0] i_new_sp,
  input wire [31:0] i_new_fp,
  input wire [31:0] i_rip,
  input wire [31:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_opnd_a,
  output reg [31:0] o_opnd_b,
  output wire o_stall,
  output wire o_busy_ret,
  output wire [31:0] o_frame_pointer,
  output wire [31:0] o_stack_pointer,
  output reg [31:0] o_rdata,
  output reg o_rd_err
);
  reg [31:0] glob [0:15];
  reg [31:0] loc [0:15];
  reg [1:0] state;
  wire [511:0] loc_flat;
  wire [511:0] cache_set;
  wire [31:0] busy;
  reg [31:0] set_mask;
  reg [31:0] clr_mask;
  reg [31:0] next_a;
  reg [31:0] next_b;
  integer k;
  genvar gi;

  // Bit mask for a register group of 1, 2, 3 or 4
  function [31:0] group_mask;
    input [4:0] base;
    input [1:0] cnt;
    reg [31:0] one;
    begin
      one = 32'h00000001 << base;
      case (cnt)
        2'h1: group_mask = one | (one << 1);
        2'h2: group_mask = one | (one << 1) | (one << 2);
        2'h3: group_mask = one | (one << 1) | (one << 2) | (one << 3);
        default: group_mask = one;
      endcase
    end
  endfunction

  // Operand value: literal or register, local/global by bit 4
  function [31:0] opnd_val;
    input [4:0] sel;
    input lit;
    input [31:0] gv;
    input [31:0] lv;
    begin
      if (lit) begin
        opnd_val = {27'h0, sel}; // [RL8]
      end else if (sel[4]) begin
        opnd_val = lv; // [RL13]
      end else begin
        opnd_val = gv; // [RL13]
      end
    end
  endfunction

  function src_busy;
    input [4:0] sel;
    input lit;
    input [31:0] bz;
    begin
      src_busy = !lit && bz[sel];
    end
  endfunction

  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_flat
      assign loc_flat[gi*32 +: 32] = loc[gi];
    end
  endgenerate

  assign o_stall = i_issue && (src_busy(i_src_a, i_src_a_lit, busy) ||
                   src_busy(i_src_b, i_src_b_lit, busy) ||
                   (i_dst_en && |(busy & group_mask(i_dst, i_dst_cnt)))); // [RL12] [RL11]
  assign o_busy_ret = (state != `ORFS_ST_IDLE);
  assign o_frame_pointer = glob[`ORFS_FRAME_SLOT]; // [RL2]
  assign o_stack_pointer = loc[`ORFS_SP_SLOT];

  always @* begin
    set_mask = 32'h00000000;
    clr_mask = 32'h00000000;
    if (i_issue && !o_stall && i_dst_en && i_multi) begin
      set_mask = group_mask(i_dst, i_dst_cnt); // [RL10]
    end
    if (i_wb_en && i_wb_pending) begin
      clr_mask = 32'h00000001 << i_wb_reg; // [RL14]
    end
  end

  orfs_scoreboard orfs_scoreboard_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_set_mask(set_mask),
    .i_clr_mask(clr_mask),
    .o_busy(busy)
  );

  orfs_local_cache orfs_local_cache_inst (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_save(i_call && state == `ORFS_ST_IDLE),
    .i_restore(i_ret && state == `ORFS_ST_IDLE),
    .i_set(loc_flat),
    .o_set(cache_set),
    .o_empty()
  );

  always @* begin
    next_a = opnd_val(i_src_a, i_src_a_lit, glob[i_src_a[3:0]], loc[i_src_a[3:0]]);
    next_b = opnd_val(i_src_b, i_src_b_lit, glob[i_src_b[3:0]], loc[i_src_b[3:0]]);
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_opnd_a <= 32'h00000000;
      o_opnd_b <= 32'h00000000;
    end else begin
      o_opnd_a <= next_a;
      o_opnd_b <= next_b;
    end
  end

  // Globals; all reset to zero except global zero, which gets the identification
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (k = 0; k < 16; k = k + 1) begin
        glob[k] <= 32'h00000000;
      end
      glob[0] <= `ORFS_ID_VALUE; // [RL3]
    end else begin
      if (i_wb_en && !i_wb_reg[4]) begin
        glob[i_wb_reg[3:0]] <= i_wb_data; // [RL1]
      end
      if (i_call && state == `ORFS_ST_IDLE) begin
        glob[`ORFS_FRAME_SLOT] <= i_new_fp; // [RL2]
      end else if (i_ret && state == `ORFS_ST_IDLE) begin
        glob[`ORFS_FRAME_SLOT] <= loc[`ORFS_PFP_SLOT]; // [RL2]
      end
    end
  end

  // Local set: call saves it and seeds pointer slots, return restores
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= `ORFS_ST_IDLE;
    end else begin
      case (state)
        `ORFS_ST_IDLE: begin
          if (i_call) begin
            state <= `ORFS_ST_CALL;
          end else if (i_ret) begin
            state <= `ORFS_ST_RET;
          end
        end
        `ORFS_ST_CALL: state <= `ORFS_ST_IDLE;
        `ORFS_ST_RET: state <= `ORFS_ST_IDLE;
        default: state <= `ORFS_ST_IDLE;
      endcase
    end
  end

  // Locals carry no reset; fresh sets keep stale contents outside pointer slots 0-2
  always @(posedge i_clk_sys) begin
    if (i_call && state == `ORFS_ST_IDLE) begin
      loc[`ORFS_PFP_SLOT] <= glob[`ORFS_FRAME_SLOT]; // [RL5] [RL6] [RL7]
      loc[`ORFS_SP_SLOT] <= i_new_sp; // [RL6]
      loc[`ORFS_RIP_SLOT] <= i_rip; // [RL6]
    end else if (state == `ORFS_ST_RET) begin
      for (k = 0; k < 16; k = k + 1) begin
        loc[k] <= cache_set[k*32 +: 32]; // [RL5] [RL9]
      end
    end else if (i_wb_en && i_wb_reg[4]) begin
      loc[i_wb_reg[3:0]] <= i_wb_data;
    end
  end

  // Mapped register port
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
      o_rd_err <= 1'b0;
    end else begin
      o_rdata <= 32'h00000000;
      o_rd_err <= 1'b0;
      if (i_rd) begin
        if (i_addr == `ORFS_ID_ADDR) begin
          o_rdata <= `ORFS_ID_VALUE; // [RL4]
        end else begin
          o_rd_err <= 1'b1;
        end
      end
    end
  end
endmodule // orfs_regfile

// File: core/orfs_regs.vh
// Purpose: Constants for the operand register file and local cache
// Assumes: Included by the register file modules
// Notes: Identification value is arbitrary
`ifndef ORFS_REGS_VH
`define ORFS_REGS_VH
`define ORFS_ID_ADDR 32'hff008710
`define ORFS_ID_VALUE 32'h00a5a5a1
`define ORFS_FRAME_SLOT 4'hf
`define ORFS_PFP_SLOT 4'h0
`define ORFS_SP_SLOT 4'h1
`define ORFS_RIP_SLOT 4'h2
`define ORFS_CACHE_DEPTH 4
`define ORFS_CACHE_AW 2
`define ORFS_ST_IDLE 2'h0
`define ORFS_ST_CALL 2'h1
`define ORFS_ST_RET 2'h2
`endif

// File: core/orfs_scoreboard.v
// Purpose: Busy bits for 32 operand registers
// Assumes: Index 0-15 global, 16-31 local
// Notes: Set wins over clear in the same cycle
module orfs_scoreboard (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire [31:0] i_set_mask,
  input wire [31:0] i_clr_mask,
  output reg [31:0] o_busy
);
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 32'h00000000;
    end else begin
      o_busy <= (o_busy & ~i_clr_mask) | i_set_mask; // [RL10] [RL14]
    end
  end
endmodule // orfs_scoreboard

// File: sim/orfs_exec_model.sv
// Purpose: Execution unit returning one result
// Assumes: One result pending at a time
// Notes: Data line toggles when idle
module orfs_exec_model (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_start,
  input wire [31:0] i_data,
  input wire [3:0] i_lat,
  output reg o_wb_en,
  output reg [31:0] o_wb_data
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [3:0] cnt;
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 4'h0;
      o_wb_en <= 1'b0;
      o_wb_data <= 32'h0;
    end else begin
      o_wb_en <= cnt == 4'h1;
      o_wb_data <= cnt == 4'h1 ? i_data : ~o_wb_data;
      cnt <= i_start ? i_lat : cnt - {3'h0, cnt != 4'h0};
    end
  end
endmodule // orfs_exec_model

// File: sim/orfs_regfile_sva.sv
// Purpose: Port checks for the register file
// Assumes: One clock, async low reset
// Notes: Bound to every instance
`include "orfs_regs.vh"
module orfs_regfile_sva (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire [4:0] i_src_a,
  input wire i_src_a_lit,
  input wire i_src_b_lit,
  input wire i_issue,
  input wire i_dst_en,
  input wire [4:0] i_dst,
  input wire [1:0] i_dst_cnt,
  input wire i_multi,
  input wire i_wb_en,
  input wire i_call,
  input wire i_ret,
  input wire [31:0] i_new_fp,
  input wire [31:0] i_addr,
  input wire i_rd,
  input wire [31:0] o_opnd_a,
  input wire o_stall,
  input wire o_busy_ret,
  input wire [31:0] o_frame_pointer,
  input wire [31:0] o_rdata,
  input wire o_rd_err
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_mul;
    i_issue && !o_stall && i_dst_en && i_multi && i_dst_cnt == 2'h0;
  endsequence
  sequence s_use;
    i_issue && !i_src_a_lit && i_src_a == $past(i_dst) && !i_wb_en;
  endsequence
  property p_id; i_rd && i_addr == `ORFS_ID_ADDR |=> o_rdata == `ORFS_ID_VALUE && !o_rd_err; endproperty
  property p_bad; i_rd && i_addr != `ORFS_ID_ADDR |=> o_rd_err; endproperty
  property p_quiet; !i_rd |=> !o_rd_err; endproperty
  property p_lit; i_src_a_lit |=> o_opnd_a == {27'h0, $past(i_src_a)}; endproperty
  property p_free; i_issue && i_src_a_lit && i_src_b_lit && !i_dst_en |-> !o_stall; endproperty
  property p_stall; s_mul ##1 s_use |-> o_stall; endproperty
  property p_call; i_call && !i_ret && !o_busy_ret |=> o_busy_ret && o_frame_pointer == $past(i_new_fp); endproperty
  property p_ret; i_ret && !i_call && !o_busy_ret |=> o_busy_ret ##1 !o_busy_ret; endproperty
  a_id: assert property (p_id) else $error("id read wrong");
  a_bad: assert property (p_bad) else $error("no read error");
  a_quiet: assert property (p_quiet) else $error("stray read error");
  a_lit: assert property (p_lit) else $error("literal wrong");
  a_free: assert property (p_free) else $error("needless stall");
  a_stall: assert property (p_stall) else $error("missing stall");
  a_call: assert property (p_call) else $error("call wrong");
  a_ret: assert property (p_ret) else $error("return wrong");
endmodule // orfs_regfile_sva
bind orfs_regfile orfs_regfile_sva orfs_regfile_sva_inst (.*);

// File: sim/tb_orfs_regfile.sv
// Purpose: Bench for the register file
// Assumes: Model returns results
// Notes: Pending flag raised for the scoreboard test
`include "orfs_regs.vh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module tb_orfs_regfile;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 0, i_rst_n = 0, i_src_a_lit = 0, i_src_b_lit = 0, i_issue = 0, i_dst_en = 0;
  logic i_multi = 0, i_call = 0, i_ret = 0, i_wr = 0, i_rd = 0, go = 0, i_wb_pending = 0;
  logic [4:0] i_src_a = '0, i_src_b = '0, i_dst = '0, i_wb_reg = '0;
  logic [1:0] i_dst_cnt = '0;
  logic [3:0] lat = '0;
  logic [31:0] i_new_sp = '0, i_new_fp = '0, i_rip = '0, i_addr = '0, i_wdata = '0, mdat = '0;
  wire i_wb_en, o_stall, o_busy_ret, o_rd_err;
  wire [31:0] i_wb_data, o_opnd_a, o_opnd_b, o_frame_pointer, o_stack_pointer, o_rdata;
  int miscompares = 0, num_checks = 0, n;
  orfs_regfile orfs_regfile_inst (.*);
  orfs_exec_model orfs_exec_model_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(go),
    .i_data(mdat), .i_lat(lat), .o_wb_en(i_wb_en), .o_wb_data(i_wb_data));
  always #10 i_clk_sys = ~i_clk_sys;
  task tick;
    @(posedge i_clk_sys);
  endtask
  task rd(input [31:0] a, input [31:0] e, input er);
    tick;
    i_addr <= a;
    i_rd <= 1'b1;
    tick;
    i_rd <= 1'b0;
    #1 `CHK("rd_err", er, o_rd_err);
    if (!er) `CHK("rdata", e, o_rdata);
  endtask
  task wr(input [31:0] a, input [31:0] d);
    tick;
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    tick;
    i_wr <= 1'b0;
  endtask
  task opr(input [4:0] c, input l, input [31:0] e);
    tick;
    i_src_a <= c;
    i_src_b <= c;
    i_src_a_lit <= l;
    i_src_b_lit <= l;
    tick;
    #1 `CHK("opnd_a", e, o_opnd_a);
    `CHK("opnd_b", e, o_opnd_b);
  endtask
  task mw(input [4:0] r, input [31:0] d, input [3:0] l);
    tick;
    go <= 1'b1;
    i_wb_reg <= r;
    mdat <= d;
    lat <= l;
    tick;
    go <= 1'b0;
    repeat (l + 1) tick;
  endtask
  task results;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    results();
  end
  initial begin
    repeat (4) tick;
    i_rst_n <= 1'b1;
    opr(5'h00, 1'b0, `ORFS_ID_VALUE);
    rd(`ORFS_ID_ADDR, `ORFS_ID_VALUE, 1'b0);
    wr(`ORFS_ID_ADDR, 32'h0);
    rd(`ORFS_ID_ADDR, `ORFS_ID_VALUE, 1'b0);
    rd(`ORFS_ID_ADDR + 32'h4, 32'h0, 1'b1);
    mw(5'h00, 32'h5555_0000, 4'h1);
    opr(5'h00, 1'b0, 32'h5555_0000);
    $display("test ident done");
    for (int k = 0; k < 32; k++) opr(k[4:0], 1'b1, k);
    $display("test literal done");
    mw(5'h05, 32'h1234_5678, 4'h1);
    mw(5'h0f, 32'h0000_1000, 4'h3);
    tick;
    i_call <= 1'b1;
    i_new_sp <= 32'h2000_0040;
    i_new_fp <= 32'h2000_0000;
    i_rip <= 32'h0000_0abc;
    tick;
    i_call <= 1'b0;
    #1 `CHK("sp", 32'h2000_0040, o_stack_pointer);
    opr(5'h10, 1'b0, 32'h0000_1000);
    opr(5'h12, 1'b0, 32'h0000_0abc);
    opr(5'h05, 1'b0, 32'h1234_5678);
    tick;
    i_ret <= 1'b1;
    tick;
    i_ret <= 1'b0;
    tick;
    #1 `CHK("fp", 32'h0000_1000, o_frame_pointer);
    $display("test call done");
    tick;
    {i_issue, i_dst_en, i_multi, i_src_a_lit, i_src_b_lit, go} <= 6'h3f;
    i_wb_pending <= 1'b1;
    i_dst <= 5'h16;
    i_wb_reg <= 5'h16;
    mdat <= 32'hcafe_0006;
    lat <= 4'h5;
    tick;
    {i_dst_en, i_multi, i_src_a_lit, go} <= 4'h0;
    i_src_a <= 5'h16;
    #1 `CHK("stall", 1'b1, o_stall);
    tick;
    i_src_a_lit <= 1'b1;
    #1 `CHK("stall", 1'b0, o_stall);
    tick;
    i_src_a_lit <= 1'b0;
    #1 n = 0;
    while (o_stall && n < 20) begin
      tick;
      #1 n++;
    end
    `CHK("stall_len", 4, n);
    tick;
    i_issue <= 1'b0;
    opr(5'h16, 1'b0, 32'hcafe_0006);
    $display("test scoreboard done");
    results();
  end
endmodule // tb_orfs_regfile
